// ### pkg/dlc_defines.svh
// Constants for the converter input latch control block.
// Assumes inclusion by bare name from the package and design files.
`ifndef DLC_DEFINES_SVH
`define DLC_DEFINES_SVH

// Sample word width and coding span
`define DLC_WORD_W 12
`define DLC_FULL_CODE 12'hFFF
`define DLC_CODE_SUM 13'h0FFF
`define DLC_WORD_RST 12'h000

// Buffer depth in words
`define DLC_FIFO_DEPTH 32

// Synchroniser and flag reset levels
`define DLC_LOW 1'b0
`define DLC_HIGH 1'b1

// Phase encodings, Gray along the usual path
`define DLC_PH_IDLE 2'h0
`define DLC_PH_CAPTURED 2'h1
`define DLC_PH_UPDATED 2'h3

`endif

// ### pkg/dlc_pkg.sv
// Types shared by the latch control block and its bench models.
// Assumes dlc_defines.svh is on the include path.
`include "dlc_defines.svh"

package dlc_pkg;

	// One converter sample in straight binary
	typedef logic [`DLC_WORD_W-1:0] dlc_word_t;

	// Master-slave latch phase
	typedef enum logic [1:0] {
		DLC_PH_IDLE = `DLC_PH_IDLE,
		DLC_PH_CAPTURED = `DLC_PH_CAPTURED,
		DLC_PH_UPDATED = `DLC_PH_UPDATED
	} dlc_phase_t;

endpackage

// ### core/dlc_fifo.sv
// Sample buffer: parameterised FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defines.svh"

module dlc_fifo #(
	parameter int WIDTH = `DLC_WORD_W,
	parameter int DEPTH = `DLC_FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// Fill side
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	// Drain side
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wptr_q, rptr_q;
	logic [CW-1:0] cnt_q, cnt_d;
	logic ready_q, out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	logic wr, load;

	// Pointer wrap that also serves non-power-of-two depths
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == LAST_PTR) ? '0 : p + 1'b1;
	endfunction

	// Write when not full; refill output register when it empties or drains
	assign wr = i_valid & ready_q;
	assign load = (cnt_q != '0) & (~out_valid_q | i_ready);
	assign cnt_d = cnt_q + CW'(wr) - CW'(load);

	// Storage array, no reset needed
	always_ff @(posedge i_ref_clk) begin
		if (i_clk_en && wr) begin
			mem_q[wptr_q] <= i_data;
		end
	end

	// Pointers, occupancy and a registered ready flag, so the top output leaves a flop
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
			ready_q <= `DLC_HIGH;
		end else if (i_clk_en) begin
			if (wr) wptr_q <= bump(wptr_q);
			if (load) rptr_q <= bump(rptr_q);
			cnt_q <= cnt_d;
			ready_q <= (cnt_d != FULL_CNT);
		end
	end

	// Head word held in a register so reads are glitch-free
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_valid_q <= `DLC_LOW;
			out_data_q <= '0;
		end else if (i_clk_en) begin
			if (load) begin
				out_valid_q <= `DLC_HIGH;
				out_data_q <= mem_q[rptr_q];
			end else if (i_ready) begin
				out_valid_q <= `DLC_LOW;
			end
		end
	end

	assign o_ready = ready_q;
	assign o_valid = out_valid_q;
	assign o_data = out_data_q;
endmodule
`default_nettype wire

// ### core/dlc_top.sv
// Input latch control for a 12-bit current-output converter.
// Assumes a 100 MHz reference clock, a converter clock pin much slower than it,
// and host logic on the reference clock filling the sample buffer.
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defines.svh"

module dlc_top #(
	parameter int WORD_W = `DLC_WORD_W,
	parameter int FIFO_DEPTH = `DLC_FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// Host sample stream
	input wire logic i_sample_valid,
	input wire dlc_pkg::dlc_word_t i_sample_word,
	output logic o_sample_ready,
	// Converter clock pin
	input wire logic i_conv_clk,
	// Static control pins
	input wire logic i_power_down_request,
	input wire logic i_power_down_oe,
	input wire logic i_ref_select_ext,
	// Converter side
	output dlc_pkg::dlc_word_t o_sample_out,
	output dlc_pkg::dlc_word_t o_code_true,
	output dlc_pkg::dlc_word_t o_code_comp,
	output logic o_standby,
	output logic o_int_ref_enable,
	output logic o_ref_pin_oe,
	output logic o_underrun
);
	import dlc_pkg::*;

	dlc_word_t fifo_data, master_q, out_q, true_q, comp_q;
	dlc_phase_t phase_q;
	logic fifo_valid, fifo_ready;
	logic ck_s1_q, ck_s2_q, ck_s3_q, rise_ev, fall_ev;
	logic pd_s1_q, pd_s2_q, oe_s1_q, oe_s2_q, standby_q;
	logic rs_s1_q, rs_s2_q, int_ref_q;
	logic underrun_q;
	logic cap_go, upd_go;

	// Complement code: remainder of full scale after the true share
	function automatic dlc_word_t comp_code(input dlc_word_t w);
		return `DLC_FULL_CODE - w;
	endfunction

	// Stage strobe: an enabled pin edge seen outside standby
	function automatic logic stage_go(input logic en, input logic ev, input logic sb);
		return en & ev & ~sb;
	endfunction

	// Sample buffer between host stream and master stage
	dlc_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_valid(i_sample_valid),
		.i_data(i_sample_word),
		.o_ready(o_sample_ready),
		.o_valid(fifo_valid),
		.o_data(fifo_data),
		.i_ready(fifo_ready)
	);

	// A pin edge reaches its strobe two or three cycles late, so each converter
	// clock phase must span at least three reference cycles
	// Converter clock pin passes two flops; third flop only for edge detection
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ck_s1_q <= `DLC_LOW;
			ck_s2_q <= `DLC_LOW;
			ck_s3_q <= `DLC_LOW;
		end else if (i_clk_en) begin
			ck_s1_q <= i_conv_clk;
			ck_s2_q <= ck_s1_q;
			ck_s3_q <= ck_s2_q;
		end
	end

	// Duty cycle is free as long as each phase spans a few reference cycles
	assign rise_ev = ck_s2_q & ~ck_s3_q;
	assign fall_ev = ~ck_s2_q & ck_s3_q;

	// Request level and its driven flag each pass two flops before they meet;
	// an undriven pin then reads low, as its pull-down would make it
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pd_s1_q <= `DLC_LOW;
			pd_s2_q <= `DLC_LOW;
			oe_s1_q <= `DLC_LOW;
			oe_s2_q <= `DLC_LOW;
			standby_q <= `DLC_LOW;
		end else if (i_clk_en) begin
			pd_s1_q <= i_power_down_request;
			pd_s2_q <= pd_s1_q;
			oe_s1_q <= i_power_down_oe;
			oe_s2_q <= oe_s1_q;
			standby_q <= oe_s2_q & pd_s2_q;
		end
	end

	// Reference select; reset to internal reference so the pin is driven early
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rs_s1_q <= `DLC_LOW;
			rs_s2_q <= `DLC_LOW;
			int_ref_q <= `DLC_HIGH;
		end else if (i_clk_en) begin
			rs_s1_q <= i_ref_select_ext;
			rs_s2_q <= rs_s1_q;
			int_ref_q <= ~rs_s2_q;
		end
	end

	// Strobes shared by the pop, both latch stages and the underrun flag
	assign cap_go = stage_go(i_clk_en, rise_ev, standby_q);
	// A fall only counts after a capture, so a stray fall cannot move the output
	assign upd_go = stage_go(i_clk_en, fall_ev, standby_q) & (phase_q == DLC_PH_CAPTURED);

	// Pop the buffer head only on a capture edge outside standby
	assign fifo_ready = cap_go;

	// Master stage: whole word taken on the rise, bit order kept
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			master_q <= `DLC_WORD_RST;
		end else if (cap_go && fifo_valid) begin
			master_q <= fifo_data;
		end
	end

	// Empty buffer at a rise repeats the old word and flags it for one cycle
	// Repeating the last word keeps the analog output from jumping to zero
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			underrun_q <= `DLC_LOW;
		end else if (i_clk_en) begin
			underrun_q <= cap_go & ~fifo_valid;
		end
	end

	// Phase tracker keeps a fall without a prior rise from moving the output
	// Standby drops it to idle, so the first fall after standby needs a new rise
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase_q <= DLC_PH_IDLE;
		end else if (i_clk_en) begin
			unique case (phase_q)
				DLC_PH_IDLE: begin
					if (standby_q) phase_q <= DLC_PH_IDLE;
					else if (rise_ev) phase_q <= DLC_PH_CAPTURED;
				end
				DLC_PH_CAPTURED: begin
					if (standby_q) phase_q <= DLC_PH_IDLE;
					else if (fall_ev) phase_q <= DLC_PH_UPDATED;
				end
				DLC_PH_UPDATED: begin
					if (standby_q) phase_q <= DLC_PH_IDLE;
					else if (rise_ev) phase_q <= DLC_PH_CAPTURED;
				end
				default: phase_q <= DLC_PH_IDLE;
			endcase
		end
	end

	// Slave stage and both output codes, loaded together on the fall
	// Codes reset to zero scale so the complement carries the whole current
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_q <= `DLC_WORD_RST;
			true_q <= `DLC_WORD_RST;
			comp_q <= `DLC_FULL_CODE;
		end else if (upd_go) begin
			out_q <= master_q;
			true_q <= master_q;
			comp_q <= comp_code(master_q);
		end
	end

	assign o_sample_out = out_q;
	assign o_code_true = true_q;
	assign o_code_comp = comp_q;
	assign o_standby = standby_q;
	assign o_int_ref_enable = int_ref_q;
	assign o_ref_pin_oe = int_ref_q;
	assign o_underrun = underrun_q;

	// Checks on the latch path and static pins
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);

	capture_on_rise_a: assert property (
		(i_clk_en && rise_ev && !standby_q && fifo_valid) |=> master_q == $past(fifo_data)
	) else $error("master stage missed the word on a rise");

	word_order_a: assert property (
		o_code_true == o_sample_out
	) else $error("true code differs from the output word");

	update_on_fall_a: assert property (
		(i_clk_en && fall_ev && phase_q == DLC_PH_CAPTURED && !standby_q)
			|=> o_sample_out == $past(master_q)
	) else $error("output not loaded from master on a fall");

	hold_between_a: assert property (
		!(i_clk_en && fall_ev) |=> $stable(o_sample_out)
	) else $error("output changed away from a falling edge");

	code_sum_a: assert property (
		{1'b0, o_code_true} + {1'b0, o_code_comp} == `DLC_CODE_SUM
	) else $error("complement code does not fill full scale");

	standby_entry_a: assert property (
		(i_clk_en && i_power_down_oe && i_power_down_request)[*3] |=> o_standby
	) else $error("standby not entered on a driven high request");

	standby_freeze_a: assert property (
		o_standby |=> $stable(master_q) && $stable(o_sample_out)
	) else $error("latches moved during standby");

	pull_down_a: assert property (
		(i_clk_en && !i_power_down_oe)[*3] |=> !o_standby
	) else $error("undriven request did not read low");

	int_ref_a: assert property (
		(i_clk_en && !i_ref_select_ext)[*3] |=> o_int_ref_enable && o_ref_pin_oe
	) else $error("internal reference not enabled");

	ext_ref_a: assert property (
		(i_clk_en && i_ref_select_ext)[*3] |=> !o_int_ref_enable && !o_ref_pin_oe
	) else $error("reference pin still driven in external mode");

	// Underrun, phase, standby exit, complement code, buffer head and clock-enable checks
	underrun_keep_a: assert property (
		(i_clk_en && rise_ev && !standby_q && !fifo_valid) |=> o_underrun && $stable(master_q)
	) else $error("empty buffer at a rise did not flag and hold");

	underrun_once_a: assert property (
		(i_clk_en && o_underrun) |=> !o_underrun
	) else $error("underrun flag stood longer than one cycle");

	pop_only_rise_a: assert property (
		!(i_clk_en && rise_ev) |=> $stable(master_q)
	) else $error("master stage moved away from a rising edge");

	rise_arms_a: assert property (
		(i_clk_en && rise_ev && !standby_q) |=> phase_q == DLC_PH_CAPTURED
	) else $error("rise did not arm the output update");

	fall_ignored_a: assert property (
		(i_clk_en && fall_ev && phase_q != DLC_PH_CAPTURED) |=> $stable(o_sample_out)
	) else $error("fall without a capture moved the output");

	standby_idle_a: assert property (
		(i_clk_en && o_standby) |=> phase_q == DLC_PH_IDLE
	) else $error("standby left the update armed");

	standby_exit_a: assert property (
		(i_clk_en && !i_power_down_request)[*3] |=> !o_standby
	) else $error("standby held with the request low");

	comp_update_a: assert property (
		(i_clk_en && fall_ev && phase_q == DLC_PH_CAPTURED && !standby_q)
			|=> o_code_comp == `DLC_FULL_CODE - $past(master_q)
	) else $error("complement code not loaded on a fall");

	full_pop_ready_a: assert property (
		(i_clk_en && rise_ev && !standby_q && fifo_valid && !o_sample_ready) |=> o_sample_ready
	) else $error("pop from a full buffer did not free a slot");

	head_kept_a: assert property (
		(fifo_valid && !fifo_ready) |=> fifo_valid && $stable(fifo_data)
	) else $error("buffer head changed before it was taken");

	enable_freeze_a: assert property (
		!i_clk_en |=> $stable(o_sample_out) && $stable(master_q) && $stable(o_standby)
			&& $stable(o_sample_ready) && $stable(o_int_ref_enable)
	) else $error("state moved while the clock enable was low");

	// Main scenarios
	cover_update_c: cover property (
		phase_q == DLC_PH_CAPTURED ##[1:50] phase_q == DLC_PH_UPDATED
	);
	cover_underrun_c: cover property (o_underrun);
	cover_standby_c: cover property (!o_standby ##1 o_standby);
	cover_full_c: cover property (!o_sample_ready);
	cover_ext_ref_c: cover property (!o_int_ref_enable);
endmodule
`default_nettype wire

// ### tb/dlc_host.sv
// Host-side model: offers sample words and makes the converter clock.
// Assumes the bench calls its tasks; all changes land at falling ref edges.
`timescale 1ns/1ps
`default_nettype none

module dlc_host (
	// Clock and flow control
	input wire logic i_ref_clk,
	input wire logic i_ready,
	// Driven pins
	output logic o_valid,
	output dlc_pkg::dlc_word_t o_word,
	output logic o_conv_clk
);
	import dlc_pkg::*;

	// Converter clock stands low outside frames
	initial begin
		o_valid = 1'b0;
		o_word = 12'h5A5;
		o_conv_clk = 1'b0;
	end

	// Offer one word, bit 0 least significant; taken at the next rise if ready
	task automatic offer(input dlc_word_t w, output logic taken);
		@(negedge i_ref_clk);
		o_valid = 1'b1;
		o_word = w;
		taken = (i_ready === 1'b1);
		if (taken) begin
			@(posedge i_ref_clk);
		end
	endtask

	// Released data shows the inverse so stale values never look valid
	task automatic release_bus();
		@(negedge i_ref_clk);
		o_valid = 1'b0;
		o_word = ~o_word;
	endtask

	// One clock phase; equal phase lengths keep the duty cycle at half
	task automatic conv_edge(input logic lvl, input int hold);
		@(negedge i_ref_clk);
		o_conv_clk = lvl;
		repeat (hold) @(negedge i_ref_clk);
	endtask
endmodule
`default_nettype wire

// ### tb/dlc_top_bench.sv
// Self-checking bench for the converter input latch control block.
// Assumes dlc_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defines.svh"

module dlc_top_bench;
	import dlc_pkg::*;

	logic clk, rst_n, clk_en, pd_req, pd_oe, ref_ext, valid, ready, conv;
	logic standby, int_ref, ref_oe, underrun;
	dlc_word_t word, out, ctrue, ccomp, last;
	int failures, n_compared;

	dlc_host dlc_host_inst (.i_ref_clk(clk), .i_ready(ready), .o_valid(valid),
		.o_word(word), .o_conv_clk(conv));

	dlc_top dlc_top_inst (.i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en),
		.i_sample_valid(valid), .i_sample_word(word), .o_sample_ready(ready),
		.i_conv_clk(conv), .i_power_down_request(pd_req), .i_power_down_oe(pd_oe),
		.i_ref_select_ext(ref_ext), .o_sample_out(out), .o_code_true(ctrue),
		.o_code_comp(ccomp), .o_standby(standby), .o_int_ref_enable(int_ref),
		.o_ref_pin_oe(ref_oe), .o_underrun(underrun));

	// 100 MHz reference clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("TB: compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_word(input string what, input dlc_word_t exp, input dlc_word_t got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Bounded retry; a word never taken ends the run
	task automatic push(input dlc_word_t w);
		logic taken;
		taken = 1'b0;
		for (int k = 0; k < 50 && !taken; k++) begin
			dlc_host_inst.offer(w, taken);
		end
		if (!taken) begin
			failures++;
			$display("ERROR push timed out");
			tally_and_finish();
		end
	endtask

	// Rise captures, but the output must not move before the fall
	task automatic conv_rise();
		dlc_host_inst.conv_edge(1'b1, 6);
		chk_word("held output", last, out);
	endtask

	task automatic conv_fall(input dlc_word_t w);
		dlc_host_inst.conv_edge(1'b0, 6);
		chk_word("output word", w, out);
		chk_word("true share", w, ctrue);
		chk_word("comp share", 12'hFFF - w, ccomp);
		last = w;
	endtask

	task automatic test_reset();
		chk_bit("ready", 1'b1, ready);
		chk_word("output word", 12'h000, out);
		chk_word("comp share", 12'hFFF, ccomp);
		chk_bit("standby", 1'b0, standby);
		chk_bit("internal ref", 1'b1, int_ref);
		chk_bit("ref pin oe", 1'b1, ref_oe);
		chk_bit("underrun", 1'b0, underrun);
		$display("TB: test reset done");
	endtask

	// Next word is pushed between rise and fall to prove the capture edge
	task automatic test_stream();
		dlc_word_t tbl [5] = '{12'h001, 12'h800, 12'hFFF, 12'hA5C, 12'h000};
		push(tbl[0]);
		dlc_host_inst.release_bus();
		for (int i = 0; i < 5; i++) begin
			conv_rise();
			if (i < 4) begin
				push(tbl[i+1]);
				dlc_host_inst.release_bus();
			end
			conv_fall(tbl[i]);
		end
		$display("TB: test stream done");
	endtask

	// Fill until refused, then drain in order
	task automatic test_full();
		int n;
		logic taken;
		n = 0;
		taken = 1'b1;
		while (taken && n < 40) begin
			dlc_host_inst.offer(dlc_word_t'(12'h100 + n), taken);
			if (taken) n++;
		end
		dlc_host_inst.release_bus();
		chk_word("accepted count", 12'(`DLC_FIFO_DEPTH + 1), 12'(n));
		chk_bit("ready when full", 1'b0, ready);
		for (int k = 0; k < n; k++) begin
			conv_rise();
			if (k == 0) chk_bit("ready after pop", 1'b1, ready);
			conv_fall(dlc_word_t'(12'h100 + k));
		end
		$display("TB: test full done");
	endtask

	task automatic test_underrun();
		logic seen;
		seen = 1'b0;
		dlc_host_inst.conv_edge(1'b1, 0);
		repeat (8) begin
			@(negedge clk);
			if (underrun === 1'b1) seen = 1'b1;
		end
		chk_bit("underrun pulse", 1'b1, seen);
		conv_fall(last);
		$display("TB: test underrun done");
	endtask

	// Standby freezes the latch; an undriven request reads low
	task automatic test_standby();
		pd_req = 1'b1;
		wait_n(6);
		chk_bit("standby on", 1'b1, standby);
		push(12'h3C7);
		dlc_host_inst.release_bus();
		conv_rise();
		conv_fall(last);
		pd_oe = 1'b0;
		wait_n(6);
		chk_bit("standby off", 1'b0, standby);
		conv_rise();
		conv_fall(12'h3C7);
		pd_req = 1'b0;
		pd_oe = 1'b1;
		$display("TB: test standby done");
	endtask

	// Clock enable low must freeze the reference select path
	task automatic test_ref();
		ref_ext = 1'b1;
		clk_en = 1'b0;
		wait_n(6);
		chk_bit("frozen ref", 1'b1, int_ref);
		clk_en = 1'b1;
		wait_n(6);
		chk_bit("internal ref", 1'b0, int_ref);
		chk_bit("ref pin oe", 1'b0, ref_oe);
		ref_ext = 1'b0;
		wait_n(6);
		chk_bit("internal ref", 1'b1, int_ref);
		chk_bit("ref pin oe", 1'b1, ref_oe);
		$display("TB: test ref done");
	endtask

	// Main sequence
	initial begin
		failures = 0;
		n_compared = 0;
		last = 12'h000;
		rst_n = 1'b0;
		clk_en = 1'b1;
		pd_req = 1'b0;
		pd_oe = 1'b1;
		ref_ext = 1'b0;
		wait_n(10);
		test_reset();
		rst_n = 1'b1;
		wait_n(2);
		test_stream();
		test_full();
		test_underrun();
		test_standby();
		test_ref();
		tally_and_finish();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		$display("ERROR run timed out");
		tally_and_finish();
	end
endmodule
`default_nettype wire
